// file: rtl/fcs_defs.svh
// Purpose: constants for the flash command sequencer (host side)
// Assumes: 100 MHz clk, 10 ns period
// Notes: offsets are byte addresses on the APB side
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// register offsets
`define FCS_OFF_CTRL 8'h00
`define FCS_OFF_ADDR 8'h04
`define FCS_OFF_DATA 8'h08
`define FCS_OFF_STAT 8'h0c
`define FCS_OFF_RDATA 8'h10

// control and status field positions
`define FCS_CTRL_GO 8
`define FCS_CTRL_BYTE 16
`define FCS_STAT_DONE 1
`define FCS_STAT_ERR 2
`define FCS_DQ_TOGGLE 6
`define FCS_DQ_TIMEOUT 5

// command data values
`define FCS_D_UNL1 8'haa
`define FCS_D_UNL2 8'h55
`define FCS_D_IDENT 8'h90
`define FCS_D_SECURE 8'h88
`define FCS_D_PROG 8'ha0
`define FCS_D_BYPASS 8'h20
`define FCS_D_ERASE 8'h80
`define FCS_D_CHIP 8'h10
`define FCS_D_SECT 8'h30
`define FCS_D_RESET 8'hf0
`define FCS_D_SUSP 8'hb0
`define FCS_D_RESUME 8'h30
`define FCS_D_CFI 8'h98
`define FCS_D_EXIT 8'h00

// command addresses, word and byte mode
`define FCS_A_U1_W 12'h555
`define FCS_A_U2_W 12'h2aa
`define FCS_A_U1_B 12'haaa
`define FCS_A_U2_B 12'h555
`define FCS_A_CFI_W 12'h055
`define FCS_A_CFI_B 12'h0aa

// reset values
`define FCS_RST_BYTE 1'b0

// timing, ns and derived cycles (least times round up)
`define FCS_CLK_NS 10
`define FCS_CS_NS 10
`define FCS_WP_NS 35
`define FCS_WPH_NS 30
`define FCS_ACC_NS 90
`define FCS_CS_CYC ((`FCS_CS_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WP_CYC ((`FCS_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WPH_CYC ((`FCS_WPH_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_CYC ((`FCS_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
// longest time between added sectors rounds down
`define FCS_SECT_WIN_US 50
`define FCS_SECT_WIN_CYC ((`FCS_SECT_WIN_US * 1000) / `FCS_CLK_NS)

`endif

// file: rtl/fcs_pkg.sv
// Purpose: types for the flash command sequencer
// Assumes: constants live in fcs_defs.svh
// Notes: gray codes along the usual path
package fcs_pkg;

  typedef enum logic [3:0] {
    FCS_READ = 4'h0, FCS_RESET = 4'h1, FCS_IDQ = 4'h2,
    FCS_SEC_ENTER = 4'h3, FCS_SEC_EXIT = 4'h4, FCS_PROG = 4'h5,
    FCS_BYP_ENTER = 4'h6, FCS_BYP_PROG = 4'h7, FCS_BYP_RESET = 4'h8,
    FCS_CHIP = 4'h9, FCS_SECT = 4'ha, FCS_SECT_ADD = 4'hb,
    FCS_SUSP = 4'hc, FCS_RESUME = 4'hd, FCS_CFI = 4'he, FCS_POLL = 4'hf
  } fcs_cmd_e;

  typedef enum logic {
    FCS_M_IDLE = 1'b0,
    FCS_M_WAIT = 1'b1
  } fcs_mst_e;

  typedef enum logic [1:0] {
    FCS_E_IDLE = 2'b00,
    FCS_E_SETUP = 2'b01,
    FCS_E_STROBE = 2'b11,
    FCS_E_HOLD = 2'b10
  } fcs_est_e;

endpackage

// file: rtl/fcs_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: flash inputs synchronous to clk
// Notes: chip enable leads and trails the strobe
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module fcs_bus_cycle
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 21
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic rd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // flash pins
  output logic [ADDR_W-1:0] f_addr,
  input wire logic [15:0] f_dq_i,
  output logic [15:0] f_dq_o,
  output logic f_dq_oe,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n
);

  typedef struct packed {
    fcs_est_e st;
    logic [7:0] cnt;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
    logic [15:0] rdata;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic done;
  } fcs_cyc_s;

  fcs_cyc_s s_ff, nxt_s;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      FCS_E_IDLE:
      begin
        if (start)
        begin
          nxt_s.rd = rd;
          nxt_s.addr = addr;
          nxt_s.data = wdata;
          nxt_s.ce_n = 1'b0;
          nxt_s.dq_oe = ~rd;
          nxt_s.cnt = 8'(`FCS_CS_CYC - 1);
          nxt_s.st = FCS_E_SETUP;
        end
      end
      FCS_E_SETUP:
      begin
        // ce falls first, so the strobe edge is the later one
        if (s_ff.cnt == 8'h00)
        begin
          nxt_s.st = FCS_E_STROBE;
          if (s_ff.rd)
          begin
            nxt_s.oe_n = 1'b0;
            nxt_s.cnt = 8'(`FCS_ACC_CYC - 1);
          end
          else
          begin
            nxt_s.we_n = 1'b0;
            nxt_s.cnt = 8'(`FCS_WP_CYC - 1);
          end
        end
        else
          nxt_s.cnt = s_ff.cnt - 8'h01;
      end
      FCS_E_STROBE:
      begin
        if (s_ff.cnt == 8'h00)
        begin
          // we rises before ce, data stays until the cycle ends
          if (s_ff.rd)
            nxt_s.rdata = f_dq_i;
          nxt_s.oe_n = 1'b1;
          nxt_s.we_n = 1'b1;
          nxt_s.cnt = 8'(`FCS_WPH_CYC - 1);
          nxt_s.st = FCS_E_HOLD;
        end
        else
          nxt_s.cnt = s_ff.cnt - 8'h01;
      end
      FCS_E_HOLD:
      begin
        if (s_ff.cnt == 8'h00)
        begin
          nxt_s.ce_n = 1'b1;
          nxt_s.dq_oe = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = FCS_E_IDLE;
        end
        else
          nxt_s.cnt = s_ff.cnt - 8'h01;
      end
      default:
        nxt_s.st = FCS_E_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.ce_n <= 1'b1;
      s_ff.we_n <= 1'b1;
      s_ff.oe_n <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign done = s_ff.done;
  assign rdata = s_ff.rdata;
  assign f_addr = s_ff.addr;
  assign f_dq_o = s_ff.data;
  assign f_dq_oe = s_ff.dq_oe;
  assign f_ce_n = s_ff.ce_n;
  assign f_we_n = s_ff.we_n;
  assign f_oe_n = s_ff.oe_n;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_strobe_excl;
    !(f_we_n == 1'b0 && f_oe_n == 1'b0);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("write and output strobes low together");

  sequence s_we_pulse;
    (!f_we_n && !f_ce_n)[*4] ##1 (f_we_n && !f_ce_n);
  endsequence
  property p_we_pulse;
    $fell(f_we_n) |-> s_we_pulse;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse width or ce framing wrong");

endmodule
`default_nettype wire

// file: rtl/fcs_host.sv
// Purpose: host controller issuing flash command sequences from APB
// Assumes: one flash on synchronous-sampled pins, 100 MHz clk
// Notes: one command at a time; go is ignored while busy
//
// How it works
// - unlock is AA@555 then 55@2AA, byte AAA/555
// - all cycles write except reads and ident read
// - F0 anywhere returns to read mode
// - program: unlock, A0, then data at location
// - bypass entry 20, then A0 and data
// - bypass exit is 90 then 00
// - erase: unlock,80,unlock, then 10 or 30@sector
// - 50 us window for adding erase sectors
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module fcs_host
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int SECT_WIN_CYC = `FCS_SECT_WIN_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_byte_n,
  output logic flash_reset_n,
  input wire logic flash_ready_busy_n
);

  typedef struct packed {
    fcs_mst_e st;
    fcs_cmd_e cmd;
    logic [2:0] idx;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic tog_first;
    logic toggled;
    logic tmo;
    logic done;
    logic err;
    logic rdy;
    logic [15:0] win_cnt;
    logic start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic byte_n;
    logic reset_n;
  } fcs_host_s;

  fcs_host_s s_ff, nxt_s;
  logic stp_rd;
  logic stp_last;
  logic [ADDR_W-1:0] stp_addr;
  logic [15:0] stp_data;
  logic [ADDR_W-1:0] u1;
  logic [ADDR_W-1:0] u2;
  logic acc;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  ////////////////////////////////////////////////////////////////////////
  // cycle table: what bus cycle idx of cmd looks like
  always_comb
  begin
    u1 = s_ff.byte_mode ? ADDR_W'(`FCS_A_U1_B) : ADDR_W'(`FCS_A_U1_W);
    u2 = s_ff.byte_mode ? ADDR_W'(`FCS_A_U2_B) : ADDR_W'(`FCS_A_U2_W);
    // upper byte stays zero on command writes
    stp_rd = 1'b0;
    stp_last = 1'b0;
    stp_addr = u1;
    stp_data = {8'h00, `FCS_D_UNL1};
    // generic six cycle frame, unlock in 0-1 and 3-4
    case (s_ff.idx)
      3'd1, 3'd4:
      begin
        stp_addr = u2;
        stp_data = {8'h00, `FCS_D_UNL2};
      end
      default:
        stp_data = {8'h00, `FCS_D_UNL1};
    endcase
    case (s_ff.cmd)
      FCS_READ, FCS_POLL:
      begin
        stp_rd = 1'b1;
        stp_addr = s_ff.addr;
        stp_last = (s_ff.cmd == FCS_READ) || (s_ff.idx == 3'd1);
      end
      FCS_RESET, FCS_SUSP, FCS_RESUME:
      begin
        stp_addr = '0;
        stp_last = 1'b1;
        if (s_ff.cmd == FCS_RESET)
          stp_data = {8'h00, `FCS_D_RESET};
        else if (s_ff.cmd == FCS_SUSP)
          stp_data = {8'h00, `FCS_D_SUSP};
        else
          stp_data = {8'h00, `FCS_D_RESUME};
      end
      FCS_CFI:
      begin
        stp_addr = s_ff.byte_mode ? ADDR_W'(`FCS_A_CFI_B) :
                                    ADDR_W'(`FCS_A_CFI_W);
        stp_data = {8'h00, `FCS_D_CFI};
        stp_last = 1'b1;
      end
      FCS_SECT_ADD:
      begin
        stp_addr = s_ff.addr;
        stp_data = {8'h00, `FCS_D_SECT};
        stp_last = 1'b1;
      end
      FCS_IDQ:
      begin
        if (s_ff.idx == 3'd2)
          stp_data = {8'h00, `FCS_D_IDENT};
        if (s_ff.idx == 3'd3)
        begin
          // offset picks maker, device, lock or protect code
          stp_rd = 1'b1;
          stp_addr = s_ff.addr;
          stp_last = 1'b1;
        end
      end
      FCS_SEC_ENTER, FCS_BYP_ENTER:
      begin
        if (s_ff.idx == 3'd2)
        begin
          stp_data = (s_ff.cmd == FCS_SEC_ENTER) ?
                     {8'h00, `FCS_D_SECURE} :
                     {8'h00, `FCS_D_BYPASS};
          stp_last = 1'b1;
        end
      end
      FCS_SEC_EXIT:
      begin
        if (s_ff.idx == 3'd2)
          stp_data = {8'h00, `FCS_D_IDENT};
        if (s_ff.idx == 3'd3)
        begin
          stp_addr = '0;
          stp_data = {8'h00, `FCS_D_EXIT};
          stp_last = 1'b1;
        end
      end
      FCS_PROG:
      begin
        if (s_ff.idx == 3'd2)
          stp_data = {8'h00, `FCS_D_PROG};
        if (s_ff.idx == 3'd3)
        begin
          stp_addr = s_ff.addr;
          stp_data = s_ff.wdata;
          stp_last = 1'b1;
        end
      end
      FCS_BYP_PROG, FCS_BYP_RESET:
      begin
        stp_addr = '0;
        if (s_ff.idx == 3'd0)
          stp_data = (s_ff.cmd == FCS_BYP_PROG) ?
                     {8'h00, `FCS_D_PROG} : {8'h00, `FCS_D_IDENT};
        else
        begin
          stp_last = 1'b1;
          if (s_ff.cmd == FCS_BYP_PROG)
          begin
            stp_addr = s_ff.addr;
            stp_data = s_ff.wdata;
          end
          else
            stp_data = {8'h00, `FCS_D_EXIT};
        end
      end
      FCS_CHIP, FCS_SECT:
      begin
        if (s_ff.idx == 3'd2)
          stp_data = {8'h00, `FCS_D_ERASE};
        if (s_ff.idx == 3'd5)
        begin
          stp_last = 1'b1;
          if (s_ff.cmd == FCS_CHIP)
            stp_data = {8'h00, `FCS_D_CHIP};
          else
          begin
            stp_addr = s_ff.addr;
            stp_data = {8'h00, `FCS_D_SECT};
          end
        end
      end
      default:
        stp_last = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave and sequencer
  assign acc = psel && penable;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.pready = 1'b0;
    nxt_s.pslverr = 1'b0;
    nxt_s.start = 1'b0;
    nxt_s.reset_n = 1'b1;
    nxt_s.byte_n = ~s_ff.byte_mode;
    nxt_s.rdy = flash_ready_busy_n;
    if (s_ff.win_cnt != 16'h0000)
      nxt_s.win_cnt = s_ff.win_cnt - 16'h0001;
    // one wait state, data held stable through it
    if (acc && !s_ff.pready)
    begin
      nxt_s.pready = 1'b1;
      case (paddr)
        `FCS_OFF_CTRL: nxt_s.prdata = {15'h0, s_ff.byte_mode, 12'h0, s_ff.cmd};
        `FCS_OFF_ADDR: nxt_s.prdata = 32'(s_ff.addr);
        `FCS_OFF_DATA: nxt_s.prdata = {16'h0, s_ff.wdata};
        `FCS_OFF_STAT: nxt_s.prdata = {25'h0, s_ff.tmo, s_ff.toggled,
          s_ff.rdy, (s_ff.win_cnt != 16'h0000), s_ff.err, s_ff.done,
          (s_ff.st == FCS_M_WAIT)};
        `FCS_OFF_RDATA: nxt_s.prdata = {16'h0, s_ff.rdata};
        default:
        begin
          nxt_s.prdata = 32'h0000_0000;
          nxt_s.pslverr = 1'b1;
        end
      endcase
    end
    // writes land on the completing edge
    if (acc && s_ff.pready && pwrite)
    begin
      case (paddr)
        `FCS_OFF_CTRL:
        begin
          if (s_ff.st == FCS_M_IDLE)
          begin
            nxt_s.cmd = fcs_cmd_e'(pwdata[3:0]);
            nxt_s.byte_mode = pwdata[`FCS_CTRL_BYTE];
            if (pwdata[`FCS_CTRL_GO])
            begin
              nxt_s.idx = 3'd0;
              nxt_s.done = 1'b0;
              if (fcs_cmd_e'(pwdata[3:0]) == FCS_SECT_ADD &&
                  s_ff.win_cnt == 16'h0000)
                nxt_s.err = 1'b1;
              else
              begin
                nxt_s.start = 1'b1;
                nxt_s.st = FCS_M_WAIT;
              end
              // other commands end the sector window on the device
              if (!(pwdata[3:0] inside {FCS_SECT_ADD, FCS_READ, FCS_POLL}))
                nxt_s.win_cnt = 16'h0000;
            end
          end
        end
        `FCS_OFF_ADDR: nxt_s.addr = pwdata[ADDR_W-1:0];
        `FCS_OFF_DATA: nxt_s.wdata = pwdata[15:0];
        `FCS_OFF_STAT:
        begin
          if (pwdata[`FCS_STAT_DONE])
            nxt_s.done = 1'b0;
          if (pwdata[`FCS_STAT_ERR])
            nxt_s.err = 1'b0;
        end
        default: nxt_s.prdata = s_ff.prdata;
      endcase
    end
    // sequencer; its set wins over a clear in the same cycle
    case (s_ff.st)
      FCS_M_IDLE: nxt_s.idx = nxt_s.idx;
      FCS_M_WAIT:
      begin
        if (cyc_done)
        begin
          if (stp_rd)
          begin
            nxt_s.rdata = cyc_rdata;
            if (s_ff.cmd == FCS_POLL && s_ff.idx == 3'd0)
              nxt_s.tog_first = cyc_rdata[`FCS_DQ_TOGGLE];
            if (s_ff.cmd == FCS_POLL && s_ff.idx == 3'd1)
            begin
              nxt_s.toggled = s_ff.tog_first ^
                              cyc_rdata[`FCS_DQ_TOGGLE];
              nxt_s.tmo = cyc_rdata[`FCS_DQ_TIMEOUT];
            end
          end
          if (stp_last)
          begin
            nxt_s.st = FCS_M_IDLE;
            nxt_s.done = 1'b1;
            if (s_ff.cmd == FCS_SECT || s_ff.cmd == FCS_SECT_ADD)
              nxt_s.win_cnt = 16'(SECT_WIN_CYC);
          end
          else
          begin
            nxt_s.idx = s_ff.idx + 3'd1;
            nxt_s.start = 1'b1;
          end
        end
      end
      default: nxt_s.st = FCS_M_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.byte_mode <= `FCS_RST_BYTE;
      s_ff.byte_n <= 1'b1;
      s_ff.rdy <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  ////////////////////////////////////////////////////////////////////////
  fcs_bus_cycle #(.ADDR_W(ADDR_W)) u_cyc (
    .clk(clk),
    .rst(rst),
    .start(s_ff.start),
    .rd(stp_rd),
    .addr(stp_addr),
    .wdata(stp_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .f_addr(flash_addr),
    .f_dq_i(flash_dq_i),
    .f_dq_o(flash_dq_o),
    .f_dq_oe(flash_dq_oe),
    .f_ce_n(flash_ce_n),
    .f_we_n(flash_we_n),
    .f_oe_n(flash_oe_n)
  );

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign flash_byte_n = s_ff.byte_n;
  assign flash_reset_n = s_ff.reset_n;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_unlock;
    (s_ff.start && s_ff.cmd == FCS_PROG && s_ff.idx == 3'd0) |->
      (stp_addr == u1 && stp_data[7:0] == 8'haa && !stp_rd);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("program does not open with unlock write");

  property p_ident_read;
    (s_ff.start && s_ff.cmd == FCS_IDQ && s_ff.idx == 3'd3) |->
      (stp_rd && stp_last && stp_addr == s_ff.addr);
  endproperty
  a_ident_read: assert property (p_ident_read)
    else $error("ident fourth cycle is not a read");

  property p_reset_one;
    (s_ff.start && s_ff.cmd == FCS_RESET) |->
      (stp_last && stp_data == 16'h00f0 && !stp_rd);
  endproperty
  a_reset_one: assert property (p_reset_one)
    else $error("reset is not a single f0 write");

  property p_prog_data;
    (s_ff.start && s_ff.cmd == FCS_PROG && s_ff.idx == 3'd3) |->
      (stp_data == s_ff.wdata && stp_addr == s_ff.addr && stp_last);
  endproperty
  a_prog_data: assert property (p_prog_data)
    else $error("program data cycle wrong");

  property p_byp_prog;
    (s_ff.start && s_ff.cmd == FCS_BYP_PROG && s_ff.idx == 3'd0) |->
      (stp_data == 16'h00a0 && !stp_last);
  endproperty
  a_byp_prog: assert property (p_byp_prog)
    else $error("bypass program must open with a0");

  property p_byp_reset;
    (s_ff.start && s_ff.cmd == FCS_BYP_RESET && s_ff.idx == 3'd1) |->
      (stp_data == 16'h0000 && stp_last);
  endproperty
  a_byp_reset: assert property (p_byp_reset)
    else $error("bypass exit second write is not 00");

  sequence s_sect_last;
    s_ff.start && s_ff.cmd == FCS_SECT && s_ff.idx == 3'd5;
  endsequence
  property p_sect_erase;
    s_sect_last |-> (stp_data == 16'h0030 && stp_addr == s_ff.addr);
  endproperty
  a_sect_erase: assert property (p_sect_erase)
    else $error("sector erase last cycle wrong");

  property p_win_open;
    (s_ff.st == FCS_M_WAIT && cyc_done && stp_last &&
     s_ff.cmd == FCS_SECT) |=> (s_ff.win_cnt != 16'h0000);
  endproperty
  a_win_open: assert property (p_win_open)
    else $error("sector window not opened");

endmodule
`default_nettype wire

// file: tb/fcs_flash_model.sv
// Purpose: flash device stand-in for the host bench
// Assumes: word offsets unless byte_n is low
// Notes: logs every write for the bench to inspect
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model
#(
  parameter logic [15:0] MAKER_ID = 16'h00c5, // arbitrary value
  parameter int BUSY_READS = 3
)
(
  // flash pins
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic byte_n,
  output logic [15:0] dq_out,
  output logic ready_busy_n
);
  logic [11:0] la [64];
  logic [7:0] ld [64];
  logic [20:0] al;
  logic [11:0] ua;
  logic [7:0] pd;
  logic [15:0] drv;
  logic ident = 1'b0;
  logic tog = 1'b0;
  int n = 0;
  int step = 0;
  int busy = 0;
  ////////////////////////////////////////
  assign ua = byte_n ? 12'h555 : 12'haaa;
  always @(negedge we_n)
    if (ce_n === 1'b0)
      al = addr;
  // ce_n check keeps the power-up edge of we_n out of the log
  always @(posedge we_n)
    if (ce_n === 1'b0)
    begin
      la[n] = al[11:0];
      ld[n] = dq_in[7:0];
      n++;
      if (dq_in[7:0] == 8'hf0)
      begin
        step = 0;
        ident = 1'b0;
      end
      else if (step == 3)
      begin
        pd = dq_in[7:0];
        busy = BUSY_READS;
        step = 0;
      end
      else if (dq_in[7:0] == 8'haa && al[11:0] == ua)
        step = 1;
      else if (step == 1 && dq_in[7:0] == 8'h55)
        step = 2;
      else if (step == 2 && dq_in[7:0] == 8'ha0)
        step = 3;
      else
      begin
        ident = ident | (step == 2 && dq_in[7:0] == 8'h90);
        step = 0;
      end
    end
  always @(negedge oe_n)
    if (!ce_n && busy > 0)
      tog = ~tog;
  always @(posedge oe_n)
    if (busy > 0)
      busy--;
  // released bus shows the inverse, never a stale value
  always_comb
  begin
    if (busy > 0)
      drv = {8'h00, ~pd[7], tog, 6'h00};
    else if (ident && addr[7:0] == 8'h00)
      drv = MAKER_ID;
    else if (ident && addr[7:0] == (byte_n ? 8'h03 : 8'h06))
      drv = 16'h0099;
    else if (ident && addr[7:0] == (byte_n ? 8'h02 : 8'h04))
      drv = 16'h0000;
    else
      drv = addr[15:0] ^ 16'h5a5a;
    dq_out = (ce_n || oe_n) ? ~drv : drv;
  end
  assign ready_busy_n = (busy == 0);
endmodule
`default_nettype wire

// file: tb/fcs_host_tb_top.sv
// Purpose: bench for the flash command host
// Assumes: 100 MHz clk, sync reset
// Notes: table rows for every command but poll, some twice; poll and odd cases after
`timescale 1ns/1ps
`default_nettype none
module fcs_host_tb_top;
  typedef struct {
    logic [3:0] c;
    logic [20:0] a;
    logic b;
    int n;
    logic [11:0] fa;
    logic [7:0] fd;
    logic [7:0] ld;
    logic [15:0] rd;
  } fcs_row_s;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [20:0] fa;
  logic [15:0] dqo, dqi;
  logic oe, ce_n, we_n, oe_n, byte_n, reset_n, rb_n;
  int failures = 0;
  int checks = 0;
  int k;
  fcs_row_s rows [21] = '{
    '{0, 21'h123, 0, 0, 0, 0, 0, 16'h5b79}, '{2, 0, 0, 3, 12'h555, 8'haa,
    8'h90, 16'h00c5}, '{0, 3, 0, 0, 0, 0, 0, 16'h0099},
    '{0, 2, 0, 0, 0, 0, 0, 16'h0000},
    '{1, 0, 0, 1, 12'hfff, 8'hf0, 8'hf0, 0},
    '{0, 3, 0, 0, 0, 0, 0, 16'h5a59}, '{3, 0, 0, 3, 12'h555, 8'haa, 8'h88, 0},
    '{3, 0, 1, 3, 12'haaa, 8'haa, 8'h88, 0},
    '{4, 0, 0, 4, 12'h555, 8'haa, 8'h00, 0},
    '{6, 0, 0, 3, 12'h555, 8'haa, 8'h20, 0},
    '{7, 21'h40, 0, 2, 12'hfff, 8'ha0, 8'hc3, 0},
    '{8, 0, 0, 2, 12'hfff, 8'h90, 8'h00, 0},
    '{9, 0, 0, 6, 12'h555, 8'haa, 8'h10, 0},
    '{10, 21'h1f000, 0, 6, 12'h555, 8'haa, 8'h30, 0},
    '{11, 21'h2f000, 0, 1, 12'hfff, 8'h30, 8'h30, 0},
    '{12, 0, 0, 1, 12'hfff, 8'hb0, 8'hb0, 0},
    '{13, 0, 0, 1, 12'hfff, 8'h30, 8'h30, 0},
    '{14, 0, 0, 1, 12'h055, 8'h98, 8'h98, 0},
    '{14, 0, 1, 1, 12'h0aa, 8'h98, 8'h98, 0},
    '{1, 0, 0, 1, 12'hfff, 8'hf0, 8'hf0, 0},
    '{5, 21'h80, 0, 4, 12'h555, 8'haa, 8'hc3, 0}};
  fcs_host #(.SECT_WIN_CYC(200)) u_dut (.clk(clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(fa), .flash_dq_i(dqi), .flash_dq_o(dqo), .flash_dq_oe(oe),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_byte_n(byte_n), .flash_reset_n(reset_n),
    .flash_ready_busy_n(rb_n));
  fcs_flash_model u_fl (.addr(fa), .dq_in(dqo), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .byte_n(byte_n), .dq_out(dqi), .ready_busy_n(rb_n));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // idle cycle at the end so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [20:0] a,
    input logic b);
    int t;
    apb(1'b1, 8'h04, {11'h0, a});
    apb(1'b1, 8'h00, {15'h0, b, 7'h0, 1'b1, 4'h0, c});
    t = 0;
    do
    begin
      apb(1'b0, 8'h0c, 0);
      t++;
    end
    while (q[1] !== 1'b1 && q[2] !== 1'b1 && t < 100);
    // neither done nor err after the last poll is a hang
    if (q[2:1] !== 2'b01 && q[2:1] !== 2'b10 && q[2:1] !== 2'b11)
      failures++;
    st = q;
  endtask
  task automatic complete_run;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
    repeat (4) @(posedge clk);
    chk({pready, ce_n, we_n, oe_n, oe, reset_n}, 6'b011100);
    rst <= 1'b0;
    apb(1'b1, 8'h08, 32'h12c3);
    foreach (rows[i])
    begin
      k = u_fl.n;
      cmd(rows[i].c, rows[i].a, rows[i].b);
      chk(u_fl.n - k, rows[i].n);
      if (rows[i].n > 0 && rows[i].fa != 12'hfff)
        chk(u_fl.la[k], rows[i].fa);
      if (rows[i].n > 0)
        chk({u_fl.ld[k], u_fl.ld[u_fl.n - 1]},
          {rows[i].fd, rows[i].ld});
      if (rows[i].c == 4'h0 || rows[i].c == 4'h2)
      begin
        apb(1'b0, 8'h10, 0);
        chk(q[15:0], rows[i].rd);
      end
    end
    apb(1'b0, 8'h0c, 0);
    chk(q[4], 1'b0);
    cmd(4'hf, 21'h80, 1'b0);
    chk(st[6:5], 2'b01);
    cmd(4'ha, 21'h3f000, 1'b0);
    chk(st[3], 1'b1);
    k = u_fl.n;
    apb(1'b1, 8'h14, 32'h1);
    chk(e, 1'b1);
    repeat (250) @(posedge clk);
    cmd(4'hb, 21'h3f000, 1'b0);
    chk(st[3:2], 2'b01);
    chk(u_fl.n - k, 0);
    // mid-run reset brings the pins and flags back to idle
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({pready, ce_n, we_n, oe_n, oe, reset_n}, 6'b011100);
    apb(1'b0, 8'h0c, 0);
    chk(q[3:0], 4'h0);
    complete_run();
  end
endmodule
`default_nettype wire
